//--- design/aspc_pkg.sv
// constants for the alarm and sample period control block
package aspc_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses on the serial port)
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_ALARM2_MAGNITUDE = 6'h22;
  localparam logic [5:0] ADDR_ALARM2_SAMPLE_COUNT = 6'h26;
  localparam logic [5:0] ADDR_ALARM_CONTROL = 6'h28;
  localparam logic [5:0] ADDR_SAMPLE_PERIOD = 6'h36;
  // ----------------------------------------------------------------
  // reset values and writable bits
  // ----------------------------------------------------------------
  localparam logic [15:0] ALARM2_MAGNITUDE_RST = 16'h0000;
  localparam logic [15:0] ALARM2_SAMPLE_COUNT_RST = 16'h0000;
  localparam logic [15:0] ALARM_CONTROL_RST = 16'h0000;
  localparam logic [15:0] SAMPLE_PERIOD_RST = 16'h000a;
  localparam logic [15:0] MAGNITUDE_MASK = 16'hbfff;
  localparam logic [15:0] SAMPLE_COUNT_MASK = 16'h00ff;
  localparam logic [15:0] CONTROL_MASK = 16'hff07;
  localparam logic [15:0] PERIOD_MASK = 16'h00ff;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MAG_GT_BIT = 15;
  localparam int LIMIT_MSB = 13;
  localparam int COUNT_MSB = 7;
  localparam int CTRL_ROC2_BIT = 15;
  localparam int CTRL_SRC2_LSB = 12;
  localparam int CTRL_ROC1_BIT = 11;
  localparam int CTRL_SRC1_LSB = 8;
  localparam int CTRL_OUT_EN_BIT = 2;
  localparam int CTRL_POL_BIT = 1;
  localparam int CTRL_LINE_BIT = 0;
  localparam int PRD_BASE_BIT = 7;
  localparam int PRD_COUNT_MSB = 6;
  localparam int SPI_WRITE_BIT = 15;
  localparam int SPI_ADDR_LSB = 8;
  localparam logic [4:0] SPI_LAST_BIT = 5'h0f;
  // ----------------------------------------------------------------
  // sources: codes 2,3,6,7 are twos complement, the rest straight binary
  // ----------------------------------------------------------------
  localparam logic [2:0] SRC_DISABLED = 3'h0;
  localparam logic [7:0] SRC_SIGNED_MASK = 8'hcc;
  // ----------------------------------------------------------------
  // time bases
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int FAST_BASE_NS = 122100;
  localparam int SLOW_BASE_NS = 3784000;
  localparam int FAST_BASE_CYCLES = FAST_BASE_NS / CLK_PERIOD_NS;
  localparam int SLOW_BASE_CYCLES = SLOW_BASE_NS / CLK_PERIOD_NS;
  localparam int BASE_W = 17;
  typedef logic [13:0] aspc_sample_t;
endpackage : aspc_pkg

//--- design/aspc_period_timer.sv
// sample period generator: time base prescaler and 7-bit period counter
`timescale 1ns/1ps
module aspc_period_timer (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // setting
  input wire logic base_select,
  input wire logic [6:0] period_count,
  input wire logic [aspc_pkg::BASE_W-1:0] fast_cycles,
  input wire logic [aspc_pkg::BASE_W-1:0] slow_cycles,
  // one-cycle tick per sample period
  output logic tick
);
  logic [aspc_pkg::BASE_W-1:0] pre;
  logic [6:0] per;
  logic [aspc_pkg::BASE_W-1:0] base_last;

  assign base_last = (base_select ? slow_cycles : fast_cycles) - 1'b1; // see RULE_11

  // >= keeps the counters from running away when software shortens the period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre <= '0;
      per <= '0;
      tick <= 1'b0;
    end else if (ce) begin
      tick <= 1'b0;
      if (pre >= base_last) begin
        pre <= '0;
        if (per >= period_count) begin // see RULE_12
          per <= '0;
          tick <= 1'b1;
        end else begin
          per <= per + 7'h01;
        end
      end else begin
        pre <= pre + 1'b1;
      end
    end
  end

  property p_tick_single;
    @(posedge clk) disable iff (rst) (tick && ce) |=> !tick;
  endproperty
  a_tick_single: assert property (p_tick_single) // see RULE_12
    else $error("sample tick lasted more than one cycle");
endmodule : aspc_period_timer

//--- design/aspc_alarm_eval.sv
// one alarm: threshold or rate-of-change test on the selected source
`timescale 1ns/1ps
module aspc_alarm_eval (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // evaluation strobe and sample
  input wire logic eval,
  input wire logic enable,
  input wire logic is_signed,
  input wire aspc_pkg::aspc_sample_t value,
  // setting
  input wire logic rate_of_change_mode,
  input wire logic greater,
  input wire aspc_pkg::aspc_sample_t limit,
  input wire logic [7:0] sample_count,
  // live alarm condition
  output logic active
);
  logic signed [15:0] val_x;
  logic signed [15:0] lim_x;
  logic signed [15:0] ref_x;
  logic signed [15:0] delta;
  logic signed [24:0] scaled;
  logic [7:0] n_eff;
  logic [7:0] cnt;
  logic ref_valid;
  logic thr_hit;
  logic roc_hit;

  assign val_x = is_signed ? {{2{value[13]}}, value} : {2'b00, value}; // see RULE_02
  assign lim_x = is_signed ? {{2{limit[13]}}, limit} : {2'b00, limit};
  assign n_eff = (sample_count == 8'h00) ? 8'h01 : sample_count;
  assign delta = val_x - ref_x;
  // compare the change against limit*n instead of dividing the change by n
  assign scaled = lim_x * $signed({1'b0, n_eff});
  assign thr_hit = greater ? (val_x > lim_x) : (val_x < lim_x); // see RULE_01
  assign roc_hit = greater ? (25'(delta) > scaled) : (25'(delta) < scaled); // see RULE_04

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active <= 1'b0;
      ref_x <= '0;
      ref_valid <= 1'b0;
      cnt <= '0;
    end else if (ce) begin
      if (!enable || !rate_of_change_mode) begin
        ref_valid <= 1'b0;
        cnt <= '0;
      end
      if (!enable) begin
        active <= 1'b0;
      end else if (eval && !rate_of_change_mode) begin
        active <= thr_hit; // see RULE_18
      end else if (eval && !ref_valid) begin
        ref_x <= val_x;
        ref_valid <= 1'b1;
        cnt <= '0;
      end else if (eval) begin
        if (cnt + 8'h01 >= n_eff) begin
          active <= roc_hit; // see RULE_04
          ref_x <= val_x;
          cnt <= '0;
        end else begin
          cnt <= cnt + 8'h01;
        end
      end
    end
  end

  property p_threshold;
    @(posedge clk) disable iff (rst)
      (ce && eval && enable && !rate_of_change_mode) |=> (active == $past(thr_hit));
  endproperty
  a_threshold: assert property (p_threshold) // see RULE_01
    else $error("threshold alarm does not match comparison");

  property p_disabled;
    @(posedge clk) disable iff (rst) (ce && !enable) |=> !active;
  endproperty
  a_disabled: assert property (p_disabled) // see RULE_06
    else $error("disabled alarm is active");
endmodule : aspc_alarm_eval

//--- design/aspc_alarm_sample_ctrl.sv
// alarm 2 registers, shared alarm control, sample period control and serial access
//
// Behaviour
// RULE_01: alarm 2 magnitude bit 15 set flags above limit, clear flags below.
// RULE_02: alarm 2 limit is low fourteen bits in source format; bit 14 unused.
// RULE_03: alarm 2 sample count is eight bits; upper byte unused.
// RULE_04: rate-of-change averages change over count samples, compares against limit.
// RULE_05: control bit 15 picks rate-of-change for alarm 2, else threshold.
// RULE_06: control bits 14:12 pick alarm 2 source; zero disables it.
// RULE_07: control bit 11 picks rate-of-change for alarm 1, else threshold.
// RULE_08: control bits 10:8 pick alarm 1 source, same codes, zero disables.
// RULE_09: control bits 2,1,0: pin enable, polarity high, line one select.
// RULE_10: all seven outputs are sampled and updated together each period.
// RULE_11: period bit 7 selects 122.1 us or 3.784 ms time base.
// RULE_12: sample period is time base times low seven bits plus one.
// RULE_13: at power-up the period register holds 0x0a, about 1.343 ms.
// RULE_14: period survives reset only after a flash update command stores it.
// RULE_15: alarm 2 magnitude and count are kept in nonvolatile storage.
// RULE_16: power-up defaults hold only until the first register write.
// RULE_17: host expects about triple power at period codes 0x07 and below.
// RULE_18: hardware alarm output is not latched; follows instantaneous data.
// RULE_19: one hardware output shows either alarm, without telling which.
// RULE_20: misc control beats alarm control beats general pin control.
// RULE_21: both alarms are evaluated once per sample update on fresh data.
`timescale 1ns/1ps
module aspc_alarm_sample_ctrl #(
  parameter int SLOW_CYCLES = aspc_pkg::SLOW_BASE_CYCLES
) (
  // clock, enable and resets
  input wire logic clk,
  input wire logic ce,
  input wire logic rst,
  input wire logic por,
  // serial port
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  // command from the command register logic
  input wire logic flash_update,
  // seven output data variables
  input wire aspc_pkg::aspc_sample_t supply_data,
  input wire aspc_pkg::aspc_sample_t xaccel_data,
  input wire aspc_pkg::aspc_sample_t yaccel_data,
  input wire aspc_pkg::aspc_sample_t aux_adc_data,
  input wire aspc_pkg::aspc_sample_t temp_data,
  input wire aspc_pkg::aspc_sample_t xincl_data,
  input wire aspc_pkg::aspc_sample_t yincl_data,
  output logic sample_update,
  // alarm state and alarm 1 setting from its own registers
  input wire aspc_pkg::aspc_sample_t alarm1_limit,
  input wire logic alarm1_greater,
  input wire logic [7:0] alarm1_sample_count,
  output logic alarm1_active,
  output logic alarm2_active,
  // auxiliary lines: higher and lower priority claims
  input wire logic [1:0] misc_line_oe,
  input wire logic [1:0] misc_line_out,
  input wire logic [1:0] gpio_line_oe,
  input wire logic [1:0] gpio_line_out,
  output logic [1:0] aux_line_out,
  output logic [1:0] aux_line_oe
);
  // ----------------------------------------------------------------
  // registers and nonvolatile copies
  // ----------------------------------------------------------------
  logic [15:0] alarm2_magnitude;
  logic [15:0] alarm2_sample_count;
  logic [15:0] alarm_control;
  logic [15:0] sample_period;
  logic [15:0] nv_magnitude;
  logic [15:0] nv_sample_count;
  logic [15:0] nv_period;
  logic restore_pending;
  logic [15:0] next_reg;
  logic wr_mag;
  logic wr_cnt;
  logic wr_ctrl;
  logic wr_prd;

  // ----------------------------------------------------------------
  // serial port front end
  // ----------------------------------------------------------------
  logic cs_s1, cs_s2;
  logic sclk_s1, sclk_s2, sclk_s3;
  logic mosi_s1, mosi_s2;
  logic sclk_rise, sclk_fall;
  logic [4:0] bit_cnt;
  logic [15:0] rx_shift;
  logic [15:0] tx_shift;
  logic [15:0] frame;
  logic frame_done;
  logic [5:0] reg_addr;
  logic [15:0] read_word;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      sclk_s1 <= 1'b1;
      sclk_s2 <= 1'b1;
      sclk_s3 <= 1'b1;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
    end else if (ce) begin
      cs_s1 <= spi_cs_n;
      cs_s2 <= cs_s1;
      sclk_s1 <= spi_sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      mosi_s1 <= spi_mosi;
      mosi_s2 <= mosi_s1;
    end
  end

  assign sclk_rise = !cs_s2 && sclk_s2 && !sclk_s3;
  assign sclk_fall = !cs_s2 && !sclk_s2 && sclk_s3;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_cnt <= '0;
      rx_shift <= '0;
      frame <= '0;
      frame_done <= 1'b0;
    end else if (ce) begin
      frame_done <= 1'b0;
      if (cs_s2) begin
        bit_cnt <= '0;
      end else if (sclk_rise) begin
        rx_shift <= {rx_shift[14:0], mosi_s2};
        bit_cnt <= bit_cnt + 5'h01;
        if (bit_cnt == aspc_pkg::SPI_LAST_BIT) begin
          frame <= {rx_shift[14:0], mosi_s2};
          frame_done <= 1'b1;
          bit_cnt <= '0;
        end
      end
    end
  end

  // a read frame loads its answer here; it shifts out during the next frame
  assign reg_addr = {frame[aspc_pkg::SPI_ADDR_LSB+5:aspc_pkg::SPI_ADDR_LSB+1], 1'b0};

  always_comb begin
    unique case (reg_addr)
      aspc_pkg::ADDR_ALARM2_MAGNITUDE: read_word = alarm2_magnitude;
      aspc_pkg::ADDR_ALARM2_SAMPLE_COUNT: read_word = alarm2_sample_count;
      aspc_pkg::ADDR_ALARM_CONTROL: read_word = alarm_control;
      aspc_pkg::ADDR_SAMPLE_PERIOD: read_word = sample_period;
      default: read_word = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_shift <= '0;
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else if (ce) begin
      spi_miso_oe <= !cs_s2;
      spi_miso <= tx_shift[15];
      if (frame_done && !frame[aspc_pkg::SPI_WRITE_BIT]) begin
        tx_shift <= read_word;
      end else if (sclk_fall) begin
        tx_shift <= {tx_shift[14:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // byte writes
  // ----------------------------------------------------------------
  always_comb begin
    if (frame[aspc_pkg::SPI_ADDR_LSB]) begin
      next_reg = {frame[7:0], read_word[7:0]};
    end else begin
      next_reg = {read_word[15:8], frame[7:0]};
    end
  end

  assign wr_mag = frame_done && frame[aspc_pkg::SPI_WRITE_BIT]
                  && reg_addr == aspc_pkg::ADDR_ALARM2_MAGNITUDE;
  assign wr_cnt = frame_done && frame[aspc_pkg::SPI_WRITE_BIT]
                  && reg_addr == aspc_pkg::ADDR_ALARM2_SAMPLE_COUNT;
  assign wr_ctrl = frame_done && frame[aspc_pkg::SPI_WRITE_BIT]
                   && reg_addr == aspc_pkg::ADDR_ALARM_CONTROL;
  assign wr_prd = frame_done && frame[aspc_pkg::SPI_WRITE_BIT]
                  && reg_addr == aspc_pkg::ADDR_SAMPLE_PERIOD;

  // nonvolatile image: cleared only by power-up, not by the device reset
  always_ff @(posedge clk or posedge por) begin
    if (por) begin
      nv_magnitude <= aspc_pkg::ALARM2_MAGNITUDE_RST;
      nv_sample_count <= aspc_pkg::ALARM2_SAMPLE_COUNT_RST;
      nv_period <= aspc_pkg::SAMPLE_PERIOD_RST; // see RULE_13
    end else if (ce) begin
      if (wr_mag) begin
        nv_magnitude <= next_reg & aspc_pkg::MAGNITUDE_MASK; // see RULE_15
      end
      if (wr_cnt) begin
        nv_sample_count <= next_reg & aspc_pkg::SAMPLE_COUNT_MASK; // see RULE_15
      end
      if (flash_update) begin
        nv_period <= sample_period; // see RULE_14
      end
    end
  end

  // working copies start at their defaults, then all but the alarm control take the stored image
  always_ff @(posedge clk or posedge rst or posedge por) begin
    if (rst || por) begin
      alarm2_magnitude <= aspc_pkg::ALARM2_MAGNITUDE_RST;
      alarm2_sample_count <= aspc_pkg::ALARM2_SAMPLE_COUNT_RST;
      alarm_control <= aspc_pkg::ALARM_CONTROL_RST;
      sample_period <= aspc_pkg::SAMPLE_PERIOD_RST;
      restore_pending <= 1'b1;
    end else if (ce) begin
      restore_pending <= 1'b0;
      if (restore_pending) begin
        alarm2_magnitude <= nv_magnitude;
        alarm2_sample_count <= nv_sample_count;
        sample_period <= nv_period; // see RULE_14
      end else begin
        if (wr_mag) begin
          alarm2_magnitude <= next_reg & aspc_pkg::MAGNITUDE_MASK; // see RULE_02
        end
        if (wr_cnt) begin
          alarm2_sample_count <= next_reg & aspc_pkg::SAMPLE_COUNT_MASK; // see RULE_03
        end
        if (wr_ctrl) begin
          alarm_control <= next_reg & aspc_pkg::CONTROL_MASK; // see RULE_16
        end
        if (wr_prd) begin
          sample_period <= next_reg & aspc_pkg::PERIOD_MASK; // see RULE_16
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // sample pacing and group update
  // ----------------------------------------------------------------
  logic tick;
  aspc_pkg::aspc_sample_t src_in [8];
  aspc_pkg::aspc_sample_t held [8];

  aspc_period_timer u_timer (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .base_select(sample_period[aspc_pkg::PRD_BASE_BIT]),
    .period_count(sample_period[aspc_pkg::PRD_COUNT_MSB:0]),
    .fast_cycles(aspc_pkg::BASE_W'(aspc_pkg::FAST_BASE_CYCLES)),
    .slow_cycles(aspc_pkg::BASE_W'(SLOW_CYCLES)),
    .tick(tick)
  );

  assign src_in[0] = '0;
  assign src_in[1] = supply_data;
  assign src_in[2] = xaccel_data;
  assign src_in[3] = yaccel_data;
  assign src_in[4] = aux_adc_data;
  assign src_in[5] = temp_data;
  assign src_in[6] = xincl_data;
  assign src_in[7] = yincl_data;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_hold
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          held[gi] <= '0;
        end else if (ce && tick) begin
          held[gi] <= src_in[gi]; // see RULE_10
        end
      end
    end
  endgenerate

  // the strobe trails the capture so the alarms see the fresh group
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sample_update <= 1'b0;
    end else if (ce) begin
      sample_update <= tick; // see RULE_21
    end
  end

  // ----------------------------------------------------------------
  // alarms
  // ----------------------------------------------------------------
  logic [2:0] src1, src2;

  assign src1 = alarm_control[aspc_pkg::CTRL_SRC1_LSB+2:aspc_pkg::CTRL_SRC1_LSB]; // see RULE_08
  assign src2 = alarm_control[aspc_pkg::CTRL_SRC2_LSB+2:aspc_pkg::CTRL_SRC2_LSB]; // see RULE_06

  aspc_alarm_eval u_alarm1 (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .eval(sample_update),
    .enable(src1 != aspc_pkg::SRC_DISABLED),
    .is_signed(aspc_pkg::SRC_SIGNED_MASK[src1]),
    .value(held[src1]),
    .rate_of_change_mode(alarm_control[aspc_pkg::CTRL_ROC1_BIT]), // see RULE_07
    .greater(alarm1_greater),
    .limit(alarm1_limit),
    .sample_count(alarm1_sample_count),
    .active(alarm1_active)
  );

  aspc_alarm_eval u_alarm2 (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .eval(sample_update),
    .enable(src2 != aspc_pkg::SRC_DISABLED),
    .is_signed(aspc_pkg::SRC_SIGNED_MASK[src2]),
    .value(held[src2]),
    .rate_of_change_mode(alarm_control[aspc_pkg::CTRL_ROC2_BIT]), // see RULE_05
    .greater(alarm2_magnitude[aspc_pkg::MAG_GT_BIT]),
    .limit(alarm2_magnitude[aspc_pkg::LIMIT_MSB:0]),
    .sample_count(alarm2_sample_count[aspc_pkg::COUNT_MSB:0]),
    .active(alarm2_active)
  );

  // ----------------------------------------------------------------
  // hardware alarm pin on the auxiliary lines
  // ----------------------------------------------------------------
  logic alarm_any;
  logic alarm_level;

  assign alarm_any = alarm1_active || alarm2_active; // see RULE_19
  assign alarm_level = alarm_control[aspc_pkg::CTRL_POL_BIT] ? alarm_any : !alarm_any;

  generate
    for (gi = 0; gi < 2; gi++) begin : g_line
      logic claim;
      assign claim = alarm_control[aspc_pkg::CTRL_OUT_EN_BIT]
                     && (alarm_control[aspc_pkg::CTRL_LINE_BIT] == 1'(gi)); // see RULE_09
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          aux_line_out[gi] <= 1'b0;
          aux_line_oe[gi] <= 1'b0;
        end else if (ce) begin
          if (misc_line_oe[gi]) begin
            aux_line_out[gi] <= misc_line_out[gi]; // see RULE_20
            aux_line_oe[gi] <= 1'b1;
          end else if (claim) begin
            aux_line_out[gi] <= alarm_level; // see RULE_18
            aux_line_oe[gi] <= 1'b1;
          end else begin
            aux_line_out[gi] <= gpio_line_out[gi];
            aux_line_oe[gi] <= gpio_line_oe[gi];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_pin_priority;
    @(posedge clk) disable iff (rst)
      (ce && misc_line_oe[0]) |=> aux_line_oe[0] && aux_line_out[0] == $past(misc_line_out[0]);
  endproperty
  a_pin_priority: assert property (p_pin_priority) // see RULE_20
    else $error("misc control lost the auxiliary line");

  property p_alarm_pin;
    @(posedge clk) disable iff (rst)
      (ce && !misc_line_oe[1] && alarm_control[2:0] == 3'h7)
      |=> aux_line_oe[1] && aux_line_out[1] == $past(alarm_any);
  endproperty
  a_alarm_pin: assert property (p_alarm_pin) // see RULE_09
    else $error("alarm pin does not follow the alarms");

  property p_restore;
    @(posedge clk) disable iff (rst || por)
      (ce && restore_pending) |=> sample_period == $past(nv_period);
  endproperty
  a_restore: assert property (p_restore) // see RULE_14
    else $error("period not restored after reset");

  property p_reserved;
    @(posedge clk) disable iff (rst)
      !alarm2_magnitude[14] && alarm2_sample_count[15:8] == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) // see RULE_03
    else $error("unused register bits are set");

  property p_nv_follow;
    @(posedge clk) disable iff (rst || por)
      (ce && wr_mag && !restore_pending) |=> nv_magnitude == alarm2_magnitude;
  endproperty
  a_nv_follow: assert property (p_nv_follow) // see RULE_15
    else $error("stored magnitude differs from written value");

  property p_update;
    @(posedge clk) disable iff (rst)
      (ce && tick) |=> sample_update ##0 held[2] == $past(xaccel_data);
  endproperty
  a_update: assert property (p_update) // see RULE_10
    else $error("group update missed after sample tick");
endmodule : aspc_alarm_sample_ctrl

//--- sim/aspc_spi_host.sv
// host model: serial master issuing 16-bit frames
`timescale 1ns/1ps
module aspc_spi_host (
  // clock
  input wire logic clk,
  // serial port
  output logic spi_cs_n = 1'b1,
  output logic spi_sclk = 1'b1,
  output logic spi_mosi = 1'b0,
  input wire logic spi_miso
);
  // half period of 4 clocks keeps the pins within the 2-stage sync rate
  task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
    @(posedge clk);
    spi_cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      repeat (4) @(posedge clk);
      spi_sclk <= 1'b0;
      spi_mosi <= tx[i];
      repeat (4) @(posedge clk);
      spi_sclk <= 1'b1;
      rx[i] = spi_miso;
    end
    repeat (6) @(posedge clk);
    spi_cs_n <= 1'b1;
    // released data line shows the inverse, never the last bit
    spi_mosi <= ~tx[0];
    repeat (4) @(posedge clk);
  endtask : frame
endmodule : aspc_spi_host

//--- sim/aspc_alarm_sample_ctrl_tb.sv
// self-checking bench for the alarm and sample period block
`timescale 1ns/1ps
module aspc_alarm_sample_ctrl_tb;
  logic clk = 1'b0, rst = 1'b1, por = 1'b1, flash_update = 1'b0;
  logic spi_cs_n, spi_sclk, spi_mosi, spi_miso, sample_update, a1, a2;
  logic ce = 1'b1, miso_oe, oe_seen = 1'b0;
  logic [1:0] misc_oe = 2'h0, misc_out = 2'h0, aux_out, aux_oe;
  // lowest priority claims; line 0 shows them while the alarm sits on line 1
  logic [1:0] gpio_oe = 2'h3, gpio_out = 2'h1;
  aspc_pkg::aspc_sample_t d[7] = '{default: 14'h0};
  logic [5:0] adr[5] = '{6'h22, 6'h26, 6'h28, 6'h36, 6'h30};
  logic [15:0] rstv[5] = '{16'h0, 16'h0, 16'h0, 16'h000a, 16'h0};
  logic [15:0] msk[5] = '{16'hbfff, 16'h00ff, 16'hff07, 16'h00ff, 16'h0};
  logic [15:0] rx;
  int error_cnt = 0, comparisons = 0, cyc = 0, n_up = 0;
  always #25 clk = ~clk;
  aspc_spi_host u_host (.clk(clk), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso));
  aspc_alarm_sample_ctrl #(.SLOW_CYCLES(40)) u_dut (.clk(clk), .ce(ce), .rst(rst),
    .por(por), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe(miso_oe), .flash_update(flash_update),
    .supply_data(d[0]), .xaccel_data(d[1]), .yaccel_data(d[2]), .aux_adc_data(d[3]),
    .temp_data(d[4]), .xincl_data(d[5]), .yincl_data(d[6]),
    .sample_update(sample_update), .alarm1_limit(14'h0010), .alarm1_greater(1'b1),
    .alarm1_sample_count(8'h01), .alarm1_active(a1), .alarm2_active(a2),
    .misc_line_oe(misc_oe), .misc_line_out(misc_out), .gpio_line_oe(gpio_oe),
    .gpio_line_out(gpio_out), .aux_line_out(aux_out), .aux_line_oe(aux_oe));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    u_host.frame({2'b10, a, v[7:0]}, rx);
    u_host.frame({2'b10, a | 6'h01, v[15:8]}, rx);
  endtask : wr
  // the word read shifts out during the following frame
  task automatic rd(input logic [5:0] a, input logic [15:0] exp);
    u_host.frame({2'b00, a, 8'h00}, rx);
    u_host.frame(16'h0000, rx);
    chk(rx, exp);
  endtask : rd
  task automatic upd(input int n);
    repeat (n) @(negedge clk iff sample_update === 1'b1);
    repeat (4) @(negedge clk);
  endtask : upd
  task automatic gap(input int exp);
    int n;
    n = 0;
    @(negedge clk iff sample_update === 1'b1);
    do begin
      @(negedge clk);
      n++;
    end while (sample_update !== 1'b1);
    chk(16'(n), 16'(exp));
  endtask : gap
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      error_cnt++;
      complete_run();
    end
  end
  // the data line must be driven at least once while a frame is under way
  always @(negedge clk) begin
    if (miso_oe === 1'b1) oe_seen <= 1'b1;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    repeat (4) @(posedge clk);
    foreach (adr[i]) begin
      rd(adr[i], rstv[i]);
      wr(adr[i], 16'hffff);
      rd(adr[i], msk[i]);
    end
    chk({14'h0, miso_oe, oe_seen}, 16'h0001);
    $display("test registers done");
    wr(6'h36, 16'h0001);
    gap(4884);
    wr(6'h36, 16'h0081);
    gap(80);
    // with the enable low the period counter must not advance at all
    @(posedge clk);
    ce <= 1'b0;
    repeat (200) @(negedge clk) begin
      if (sample_update !== 1'b0) n_up++;
    end
    chk(16'(n_up), 16'h0000);
    @(posedge clk);
    ce <= 1'b1;
    $display("test period done");
    d[1] <= 14'd200;
    wr(6'h22, 16'h8064);
    wr(6'h28, 16'h2007);
    upd(2);
    chk({10'h0, aux_oe, aux_out, a1, a2}, 16'h003d);
    @(posedge clk);
    d[1] <= 14'd50;
    upd(2);
    chk({10'h0, aux_oe, aux_out, a1, a2}, 16'h0034);
    wr(6'h28, 16'h2005);
    upd(1);
    chk({10'h0, aux_oe, aux_out, a1, a2}, 16'h003c);
    wr(6'h22, 16'h0064);
    misc_oe <= 2'b10;
    misc_out <= 2'b10;
    gpio_out <= 2'h0;
    upd(2);
    chk({10'h0, aux_oe, aux_out, a1, a2}, 16'h0039);
    $display("test alarm done");
    // alarm 1 on x acceleration, rate of change over one sample against 0x10
    wr(6'h28, 16'h0a00);
    upd(2);
    chk({10'h0, aux_oe, aux_out, a1, a2}, 16'h0038);
    @(posedge clk);
    d[1] <= 14'd150;
    upd(1);
    chk({10'h0, aux_oe, aux_out, a1, a2}, 16'h003a);
    upd(1);
    chk({10'h0, aux_oe, aux_out, a1, a2}, 16'h0038);
    $display("test rate done");
    wr(6'h36, 16'h0005);
    flash_update <= 1'b1;
    @(posedge clk);
    flash_update <= 1'b0;
    // host accepts the higher power of a fast code here
    wr(6'h36, 16'h0007);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd(6'h36, 16'h0005);
    rd(6'h22, 16'h0064);
    rd(6'h28, 16'h0000);
    $display("test retention done");
    complete_run();
  end
endmodule : aspc_alarm_sample_ctrl_tb
